// File: design/therm_cfg.svh
`ifndef THERM_CFG_SVH
`define THERM_CFG_SVH
// Bus address
`define SLAVE_ADDR        7'h5A
// Register map
`define REG_CTRL_ADDR     8'h05
`define REG_FAULT_ADDR    8'h08
`define CTRL_LATCHOFF_BIT 0
`define FAULT_HOT_BIT     0
`define FAULT_COLD_BIT    1
`define CTRL_RESET        8'h00
`define FAULT_RESET       8'h00
`endif

// File: design/therm_pkg.sv
package therm_pkg;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_addr_ack, st_reg, st_reg_ack, st_wdata, st_wdata_ack, st_rdata
  } i2c_state_e;
  // Thermistor comparator results
  typedef struct packed {
    logic below_low;
    logic above_high;
  } therm_cmp_s;
endpackage

// File: design/pin_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // Both stages reset to idle-high
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pin_sync

// File: design/i2c_therm_latch.sv
`timescale 1ns/10ps
`include "therm_cfg.svh"
module i2c_therm_latch (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // I2C pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Thermistor comparators and button
  input  wire logic thermistor_low_threshold,
  input  wire logic thermistor_high_threshold,
  input  wire logic wake_button_input,
  // Charger status
  output logic      charge_enable,
  output logic      therm_fault
);
  // ****************************************
  // Synchronisers
  // ****************************************
  logic [4:0] raw_in;
  logic [4:0] syn;
  logic       scl_s;
  logic       sda_s;
  logic       btn_n;
  therm_pkg::therm_cmp_s cmp;
  logic [1:0] settle_reg;
  logic       sync_valid;

  assign raw_in = {wake_button_input, thermistor_high_threshold, thermistor_low_threshold,
                   sda_in, scl_in};

  pin_sync #(.W(5)) u_sync (
    .mclk     (mclk),
    .rstn     (rstn),
    .async_in (raw_in),
    .sync_out (syn)
  );

  // Comparators masked until the chain holds real pin samples
  assign scl_s = syn[0];
  assign sda_s = syn[1];
  assign sync_valid = settle_reg[1];
  assign cmp.below_low  = ~syn[2] & sync_valid;
  assign cmp.above_high = syn[3] & sync_valid;
  assign btn_n = syn[4];

  // Chain resets high but the high comparator idles low: hide two edges
  always_ff @(posedge mclk) begin
    if (!rstn) settle_reg <= 2'h0;
    else settle_reg <= {settle_reg[0], 1'b1};
  end

  // ****************************************
  // Bus condition detection
  // ****************************************
  logic scl_d_reg;
  logic sda_d_reg;
  logic btn_d_reg;

  // Previous sampled levels
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      btn_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      btn_d_reg <= btn_n;
    end
  end

  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire btn_press = btn_d_reg & ~btn_n;

  // ****************************************
  // Packet state machine
  // ****************************************
  therm_pkg::i2c_state_e state_reg;
  therm_pkg::i2c_state_e state_next;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] ptr_reg;
  logic       rw_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] fault_reg;
  logic       sda_oe_reg;
  logic       sda_out_reg;

  // Nine SCL rises per byte: counts 0-7 carry data, count 8 is the ack slot
  wire [7:0] shift_in  = {shift_reg[6:0], sda_s};
  wire       byte_done = scl_rise & (bit_cnt_reg == 4'h7);
  wire       ack_slot  = (bit_cnt_reg == 4'h8);
  wire       ack_rise  = scl_rise & ack_slot;
  wire       ack_end   = scl_fall & (bit_cnt_reg == 4'h0);
  wire       addr_hit  = (shift_in[7:1] == `SLAVE_ADDR);

  // Register read mux
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] c,
                                          input logic [7:0] f);
    reg_read = (a == `REG_CTRL_ADDR) ? c : (a == `REG_FAULT_ADDR) ? f : 8'h00;
  endfunction

  wire [7:0] rd_byte = reg_read(ptr_reg, ctrl_reg, fault_reg);
  // Read bit for the coming SCL high, MSB first
  wire [2:0] rd_idx   = 3'h7 - bit_cnt_reg[2:0];
  wire       rd_drive = ~rd_byte[rd_idx];
  wire wr_ctrl  = (state_reg == therm_pkg::st_wdata) & byte_done & (ptr_reg == `REG_CTRL_ADDR);
  wire wr_fault = (state_reg == therm_pkg::st_wdata) & byte_done & (ptr_reg == `REG_FAULT_ADDR);

  // Next state; no timer anywhere, states wait on bus edges only
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      therm_pkg::st_idle:      state_next = state_reg;
      therm_pkg::st_addr:      if (byte_done) begin
        state_next = addr_hit ? therm_pkg::st_addr_ack : therm_pkg::st_idle;
      end
      therm_pkg::st_addr_ack:  if (ack_end) begin
        state_next = rw_reg ? therm_pkg::st_rdata : therm_pkg::st_reg;
      end
      therm_pkg::st_reg:       if (byte_done) state_next = therm_pkg::st_reg_ack;
      therm_pkg::st_reg_ack:   if (ack_end) state_next = therm_pkg::st_wdata;
      therm_pkg::st_wdata:     if (byte_done) state_next = therm_pkg::st_wdata_ack;
      therm_pkg::st_wdata_ack: if (ack_end) state_next = therm_pkg::st_wdata;
      therm_pkg::st_rdata:     if (ack_rise & sda_s) state_next = therm_pkg::st_idle;
      default:                 state_next = therm_pkg::st_idle;
    endcase
    if (start_det) state_next = therm_pkg::st_addr;
    else if (stop_det) state_next = therm_pkg::st_idle;
  end

  // State, shifter and pointer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg   <= therm_pkg::st_idle;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      rw_reg      <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start_det) bit_cnt_reg <= 4'h0;
      else if (ack_rise) bit_cnt_reg <= 4'h0;
      else if (scl_rise) bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (scl_rise) shift_reg <= shift_in;
      if ((state_reg == therm_pkg::st_addr) & byte_done) rw_reg <= sda_s;
      if ((state_reg == therm_pkg::st_reg) & byte_done) ptr_reg <= shift_in;
      else if ((state_reg == therm_pkg::st_wdata) & byte_done) ptr_reg <= ptr_reg + 8'h01;
      else if ((state_reg == therm_pkg::st_rdata) & byte_done) ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // SDA drive: ack slots and read data, set on SCL fall, released on start or stop with SCL high
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
      if (start_det | stop_det) sda_oe_reg <= 1'b0;
      else if (scl_fall) begin
        case (state_reg)
          therm_pkg::st_addr_ack:  sda_oe_reg <= ack_slot | (rw_reg & rd_drive);
          therm_pkg::st_reg_ack,
          therm_pkg::st_wdata_ack: sda_oe_reg <= ack_slot;
          therm_pkg::st_rdata:     sda_oe_reg <= ~ack_slot & rd_drive;
          default:                 sda_oe_reg <= 1'b0;
        endcase
      end
    end
  end

  // ****************************************
  // Registers and thermal latch
  // ****************************************
  wire cmp_fault = cmp.below_low | cmp.above_high;
  wire restart   = (btn_press & ~ctrl_reg[`CTRL_LATCHOFF_BIT]) | wr_fault;
  logic chg_reg;

  // Volatile regs: defaults on power-up reset; fault set beats clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_reg  <= `CTRL_RESET;
      fault_reg <= `FAULT_RESET;
      chg_reg   <= 1'b1;
    end else begin
      if (wr_ctrl) ctrl_reg <= shift_in;
      if (wr_fault) fault_reg <= shift_in;
      if (cmp.above_high) fault_reg[`FAULT_HOT_BIT] <= 1'b1;
      if (cmp.below_low) fault_reg[`FAULT_COLD_BIT] <= 1'b1;
      if (cmp_fault) chg_reg <= 1'b0;
      else if (restart) chg_reg <= 1'b1;
    end
  end

  // ****************************************
  // Outputs from flops
  // ****************************************
  logic fault_o_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) fault_o_reg <= 1'b0;
    else fault_o_reg <= |fault_reg;
  end

  assign sda_out       = sda_out_reg;
  assign sda_oe        = sda_oe_reg;
  assign charge_enable = chg_reg;
  assign therm_fault   = fault_o_reg;
endmodule // i2c_therm_latch

// File: verification/therm_chk_sva.sv
`timescale 1ns/10ps
// Port-level checks
module therm_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic thermistor_low_threshold,
  input wire logic thermistor_high_threshold,
  input wire logic wake_button_input,
  input wire logic charge_enable,
  input wire logic therm_fault
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Thermistor outside its window
  wire bad = !thermistor_low_threshold || thermistor_high_threshold;
  AST_FAULT_SET: assert property (bad |-> ##[1:4] therm_fault)
    else $error("fault flag late");
  AST_CHG_OFF: assert property (bad |-> ##[1:4] !charge_enable)
    else $error("charging not stopped");
  AST_NO_START: assert property (bad [*6] |-> !charge_enable)
    else $error("charging during fault");
  AST_RESET: assert property ($rose(rstn) |-> charge_enable && !therm_fault)
    else $error("reset state wrong");
  AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_out)
    else $error("SDA driven high");
  AST_SDA_EDGE: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("SDA moved with SCL high");
  AST_HOLD: assert property ((sda_oe && !scl_in) [*6] ##1 !scl_in |-> sda_oe)
    else $error("SDA released early");
  AST_RESUME: assert property ($rose(charge_enable) |-> !bad)
    else $error("restart out of window");
endmodule // therm_chk
bind i2c_therm_latch therm_chk chk (.*);

// File: verification/i2c_host_model.sv
`timescale 1ns/10ps
// Bus master, SDA open drain
module i2c_host_model (
  // Pins
  input  wire logic mclk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  // Idle bus
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  // Wait n edges
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Start, SDA falls with SCL high
  task automatic start();
    sda_drv <= 1'h1;
    hold(6);
    scl <= 1'h1;
    hold(10);
    sda_drv <= 1'h0;
    hold(10);
    scl <= 1'h0;
    hold(6);
  endtask
  // Stop, SDA rises with SCL high
  task automatic stop();
    sda_drv <= 1'h0;
    hold(6);
    scl <= 1'h1;
    hold(10);
    sda_drv <= 1'h1;
    hold(10);
  endtask
  // One bit, read at mid high
  task automatic bit_x(input logic b, input int lo, output logic s);
    sda_drv <= b;
    hold(lo);
    scl <= 1'h1;
    hold(6);
    s = sda_wire;
    hold(6);
    scl <= 1'h0;
    hold(3);
  endtask
  // Byte MSB first, long ninth bit
  task automatic xfer(input logic [7:0] tx, input logic m, output logic [7:0] rx,
                      output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], 10, rx[i]);
    bit_x(m, 30, ak);
  endtask
endmodule // i2c_host_model

// File: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic mclk, rstn, lo_ok, hi_bad, btn_n;
  logic scl, sda_drv, sda_out, sda_oe, charge_enable, therm_fault, ak;
  logic [7:0] rx, d;
  logic [31:0] seed = 32'h0000D12B, r;
  int fail_count = 0;
  int checked = 0;
  wire sda_wire = sda_drv & ~sda_oe;
  initial mclk = 1'h0;
  always #2 mclk = ~mclk;
  i2c_therm_latch dut (.mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .thermistor_low_threshold(lo_ok),
    .thermistor_high_threshold(hi_bad), .wake_button_input(btn_n),
    .charge_enable(charge_enable), .therm_fault(therm_fault));
  i2c_host_model host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected fault byte
  function automatic logic [7:0] exp_fault(input logic cold, input logic hot);
    return {6'h00, cold, hot};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    host.start();
    host.xfer(8'hB4, 1'h1, rx, ak);
    chk("addr_ack", 8'h00, {7'h00, ak});
    host.xfer(p, 1'h1, rx, ak);
    host.xfer(v, 1'h1, rx, ak);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    host.start();
    host.xfer(8'hB4, 1'h1, rx, ak);
    host.xfer(p, 1'h1, rx, ak);
    host.start();
    host.xfer(8'hB5, 1'h1, rx, ak);
    host.xfer(8'hFF, 1'h1, v, ak);
    host.stop();
  endtask
  task automatic press();
    btn_n <= 1'h0;
    host.hold(10);
    btn_n <= 1'h1;
    host.hold(10);
  endtask
  // Main sequence
  initial begin
    rstn <= 1'h0;
    lo_ok <= 1'h1;
    hi_bad <= 1'h0;
    btn_n <= 1'h1;
    repeat (10) @(posedge mclk);
    rstn <= 1'h1;
    host.hold(4);
    rd(8'h08, d);
    chk("fault_rst", 8'h00, d);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      if (i == 0 || r[6:0] == 7'h5A) r[6:0] = 7'h5B;
      host.start();
      host.xfer({r[6:0], 1'h0}, 1'h1, rx, ak);
      host.stop();
      chk("foreign_nack", 8'h01, {7'h00, ak});
    end
    $display("address test done");
    r = rnd();
    wr(8'h05, r[7:0]);
    rd(8'h05, d);
    chk("latch_off", {7'h00, r[0]}, {7'h00, d[0]});
    wr(8'h05, 8'h01);
    host.start();
    host.xfer(8'hB4, 1'h1, rx, ak);
    host.xfer(8'h05, 1'h1, rx, ak);
    host.start();
    host.xfer(8'hB4, 1'h1, rx, ak);
    host.stop();
    rd(8'h05, d);
    chk("restart", 8'h01, {7'h00, d[0]});
    wr(8'h05, 8'h00);
    $display("register test done");
    lo_ok <= 1'h0;
    host.hold(10);
    chk("chg_cold", 8'h00, {7'h00, charge_enable});
    chk("fault_pin", 8'h01, {7'h00, therm_fault});
    rd(8'h08, d);
    chk("fault_cold", exp_fault(1'h1, 1'h0), d);
    wr(8'h08, 8'h00);
    press();
    chk("chg_held", 8'h00, {7'h00, charge_enable});
    lo_ok <= 1'h1;
    host.hold(10);
    chk("chg_latched", 8'h00, {7'h00, charge_enable});
    wr(8'h08, 8'h00);
    host.hold(10);
    chk("chg_clear", 8'h01, {7'h00, charge_enable});
    hi_bad <= 1'h1;
    host.hold(10);
    rd(8'h08, d);
    chk("fault_hot", exp_fault(1'h0, 1'h1), d);
    hi_bad <= 1'h0;
    press();
    chk("chg_button", 8'h01, {7'h00, charge_enable});
    hi_bad <= 1'h1;
    host.hold(10);
    hi_bad <= 1'h0;
    wr(8'h05, 8'h01);
    press();
    chk("chg_locked", 8'h00, {7'h00, charge_enable});
    rstn <= 1'h0;
    host.hold(10);
    rstn <= 1'h1;
    host.hold(4);
    chk("chg_power", 8'h01, {7'h00, charge_enable});
    chk("fault_pin_rst", 8'h00, {7'h00, therm_fault});
    rd(8'h05, d);
    chk("ctrl_rst", 8'h00, d);
    $display("thermal test done");
    stop_test();
  end
  // Watchdog, about five times the expected run
  initial begin
    #280000;
    fail_count++;
    stop_test();
  end
endmodule // testbench
